// file: logic/dsc_standby_clock.sv
// standby clock controller: oscillator gating, prescaler, divider,
// machine-cycle states and run/idle/slow/sleep/stop sequencing
// assumes oscillator clocks and stop-release arrive as slow pins
//
// Function
// - divider input is fc/4 or fc/8
// - seventh stage takes fc/2^8, fc/2^9 or fs
// - clear prescaler and divider on reset, stop
// - slow/sleep stop divider stages one to six
// - machine cycle is four main-clock states
// - cycle is 4/fc or 4/fs by mode
// - reset enters single-clock run on fc
// - idle halts CPU, interrupt releases to run
// - stop halts all, pin releases after warm-up
// - dual mode runs both oscillators, selects fm
// - slow runs on fs, fc stopped
// - idle_dual_clock returns run2, sleep returns slow
// - halt_dual_clock returns to slow if post-stop bit set, else run2
// - reset release of stop always gives run
// - control two holds enables, select, idle
// - stop release loads fc enable and select from post-stop bit
// - both oscillators off forces reset, pin low
// - control two low nibble reads as ones
// - stop bit seven starts stop
// - release type picks level or rising edge
// - warm-up field picks one of four fc lengths or two fs lengths
//
// The plain strobed port and the placing of the registers were left to the implementer.
`timescale 1ns/10ps
`default_nettype none

module dsc_standby_clock (
  input wire logic ref_clk,               // 125 MHz system clock
  input wire logic reset_n,               // async reset, active low
  input wire dsc_pkg::dsc_bus_t bus,      // register requests
  output logic [7:0] rdData,              // read data, cycle after rd
  input wire logic hfClkPin,              // high-frequency source
  input wire logic lfClkPin,              // low-frequency source
  input wire logic stopReleasePin,        // stop release input
  input wire logic intRequest,            // any interrupt request
  input wire logic intMasterEnable,       // interrupt master enable
  output dsc_pkg::dsc_clk_t clkStatus,    // main clock and mode status
  output logic [dsc_pkg::DIV_W-1:0] dividerValue, // divider stages
  output dsc_pkg::dsc_mode_t modeNow,     // current operating mode
  input wire logic resetPinIn,            // unused reset pin readback
  output logic resetPinOut,               // reset pin level when driven
  output logic resetPinOe                 // high while pulling reset low
);
  import dsc_pkg::*;

  typedef struct packed {
    logic [7:0] one;
    logic [7:0] two;
    logic [7:0] gear;
    logic [7:0] timebase;
    dsc_mode_t mode;
    logic retSlow;
    logic [PRE_W-1:0] pre;
    logic [DIV_LO_W-1:0] divLo;
    logic [DIV_W-DIV_LO_W-1:0] divHi;
    logic [1:0] mstate;
    logic [WARM_W-1:0] warmCnt;
    logic [4:0] rstOutCnt;
    logic [7:0] rdData;
    logic [1:0] hfSync;
    logic hfPrev;
    logic [1:0] lfSync;
    logic lfPrev;
    logic [1:0] stopSync;
    logic stopPrev;
    dsc_clk_t out;
  } dsc_state_t;

  dsc_state_t s;
  dsc_state_t next_s;
  logic [1:0] rstSync;
  logic rstN;

  // ********************************************************
  // helpers
  // ********************************************************
  function automatic logic preWrap(input logic [PRE_W-1:0] p,
                                   input logic sel8);
    preWrap = sel8 ? (p == 3'h7) : (p[1:0] == 2'h3);
  endfunction

  function automatic logic [WARM_W-1:0] warmTarget(
      input logic [1:0] sel, input logic toSlow, input logic dbl);
    logic [WARM_W-1:0] t;
    t = WARM_HF_0;
    if (toSlow) begin
      t = (sel == 2'h0) ? WARM_LF_0 : WARM_LF_1;
    end else begin
      unique case (sel)
        2'h0: t = WARM_HF_0;
        2'h1: t = WARM_HF_1;
        2'h2: t = WARM_HF_2;
        2'h3: t = WARM_HF_3;
      endcase
      if (dbl) begin
        t = {t[WARM_W-2:0], 1'b0};
      end
    end
    warmTarget = t;
  endfunction

  function automatic dsc_mode_t runMode(input logic lfEn,
                                        input logic sel);
    if (sel) begin
      runMode = DSC_SLOW;
    end else if (lfEn) begin
      runMode = DSC_RUN2;
    end else begin
      runMode = DSC_RUN1;
    end
  endfunction

  // ********************************************************
  // reset synchroniser
  // ********************************************************
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      rstSync <= 2'h0;
    end else begin
      rstSync <= {rstSync[0], 1'b1};
    end
  end
  assign rstN = rstSync[1];

  // ********************************************************
  // next state
  // ********************************************************
  always_comb begin
    logic hfTick;
    logic lfTick;
    logic stopRise;
    logic lowClk;
    logic halted;
    logic running;
    logic dual;
    logic fmTick;
    logic carry;
    logic loCarry;
    logic seventhFs;
    logic clearDiv;
    logic stopRel;
    logic softReset;
    logic [7:0] v;
    logic srcTick;
    next_s = s;
    hfTick = 1'b0;
    lfTick = 1'b0;
    stopRise = s.stopSync[1] & ~s.stopPrev;
    dual = s.two[TWO_LF_EN];
    lowClk = (s.mode == DSC_SLOW) || (s.mode == DSC_SLEEP);
    halted = (s.mode == DSC_HALT1) || (s.mode == DSC_HALT2);
    running = !halted && (s.mode != DSC_WARM);
    clearDiv = 1'b0;
    stopRel = 1'b0;
    softReset = 1'b0;
    v = bus.wdata;
    fmTick = 1'b0;
    carry = 1'b0;
    loCarry = 1'b0;
    seventhFs = 1'b0;
    srcTick = 1'b0;

    // pin synchronisers and edge history
    next_s.hfSync = {s.hfSync[0], hfClkPin};
    next_s.lfSync = {s.lfSync[0], lfClkPin};
    next_s.stopSync = {s.stopSync[0], stopReleasePin};
    next_s.hfPrev = s.hfSync[1];
    next_s.lfPrev = s.lfSync[1];
    next_s.stopPrev = s.stopSync[1];
    if (s.out.hfOscOn) begin
      hfTick = s.hfSync[1] & ~s.hfPrev;
    end
    if (s.out.lfOscOn) begin
      lfTick = s.lfSync[1] & ~s.lfPrev;
    end

    // timing generator
    if (running) begin
      fmTick = lowClk ? lfTick : hfTick;
      if (!lowClk && hfTick) begin
        next_s.pre = s.pre + 3'h1;
        carry = preWrap(s.pre, s.gear[GEAR_DIV_INPUT]);
      end
      if (!lowClk && carry) begin
        next_s.divLo = s.divLo + 6'h01;
        loCarry = &s.divLo;
      end
      seventhFs = lowClk || (dual && s.timebase[TIMEBASE_SEVENTH]);
      if (seventhFs ? lfTick : loCarry) begin
        next_s.divHi = s.divHi + 15'h0001;
      end
      if (fmTick) begin
        next_s.mstate = s.mstate + 2'h1;
      end
    end

    // register reads
    next_s.rdData = 8'h00;
    if (bus.rd) begin
      unique case (bus.addr)
        ADDR_STANDBY_ONE: next_s.rdData = {s.one[7:2], 2'b00};
        ADDR_STANDBY_TWO: begin
          next_s.rdData = {s.two[7:4], TWO_READ_ONES[3:0]};
        end
        ADDR_CLOCK_GEAR: next_s.rdData = s.gear;
        ADDR_TIMEBASE: next_s.rdData = s.timebase;
        default: next_s.rdData = 8'h00;
      endcase
    end

    next_s.out.idleWake = 1'b0;
    unique case (s.mode)
      DSC_RUN1, DSC_RUN2, DSC_SLOW: begin
        if (bus.wr && bus.addr == ADDR_CLOCK_GEAR) begin
          next_s.gear = v;
        end
        if (bus.wr && bus.addr == ADDR_TIMEBASE) begin
          next_s.timebase = v;
        end
        if (bus.wr && bus.addr == ADDR_STANDBY_TWO) begin
          if (!v[TWO_HF_EN] && !v[TWO_LF_EN]) begin
            softReset = 1'b1;
          end else begin
            next_s.two = {v[7:4], 4'h0};
            if (v[TWO_IDLE]) begin
              next_s.mode = (s.mode == DSC_RUN1) ? DSC_IDLE_SINGLE_CLOCK :
                            (s.mode == DSC_RUN2) ? DSC_IDLE_DUAL_CLOCK : DSC_SLEEP;
            end else begin
              next_s.mode = runMode(v[TWO_LF_EN], v[TWO_CLK_SEL]);
            end
          end
        end
        if (bus.wr && bus.addr == ADDR_STANDBY_ONE) begin
          next_s.one = {1'b0, v[6:0]};
          if (v[ONE_STOP]) begin
            next_s.mode = dual ? DSC_HALT2 : DSC_HALT1;
            next_s.retSlow = (s.mode == DSC_SLOW);
            clearDiv = 1'b1;
            if (v[ONE_RELEASE_TYPE] && s.stopSync[1]) begin
              stopRel = 1'b1;
            end
          end
        end
      end
      DSC_IDLE_SINGLE_CLOCK, DSC_IDLE_DUAL_CLOCK, DSC_SLEEP: begin
        if (intRequest) begin
          next_s.two[TWO_IDLE] = 1'b0;
          next_s.mode = (s.mode == DSC_IDLE_SINGLE_CLOCK) ? DSC_RUN1 :
                        (s.mode == DSC_IDLE_DUAL_CLOCK) ? DSC_RUN2 : DSC_SLOW;
          next_s.out.idleWake = 1'b1;
          next_s.out.wakeToIsr = intMasterEnable;
        end
      end
      DSC_HALT1, DSC_HALT2: begin
        stopRel = s.one[ONE_RELEASE_TYPE] ? s.stopSync[1] : stopRise;
      end
      DSC_WARM: begin
        srcTick = (dual && s.one[ONE_POST_STOP]) ? lfTick : hfTick;
        if (srcTick) begin
          next_s.warmCnt = s.warmCnt + 19'h00001;
          if (s.warmCnt == warmTarget(s.one[ONE_WARMUP_HI:ONE_WARMUP_LO],
                                      dual && s.one[ONE_POST_STOP],
                                      s.gear[GEAR_DIV_INPUT]) - 19'h1) begin
            next_s.mode = runMode(dual, s.two[TWO_CLK_SEL]);
            clearDiv = 1'b1;
          end
        end
      end
      default: next_s.mode = DSC_RUN1;
    endcase

    // stop release: warm-up with fc enable and select loaded from post-stop bit
    if (stopRel) begin
      next_s.mode = DSC_WARM;
      next_s.warmCnt = '0;
      clearDiv = 1'b1;
      if (dual && s.one[ONE_POST_STOP]) begin
        next_s.two[TWO_HF_EN] = 1'b0;
        next_s.two[TWO_CLK_SEL] = 1'b1;
      end else begin
        next_s.two[TWO_HF_EN] = 1'b1;
        next_s.two[TWO_CLK_SEL] = 1'b0;
      end
    end

    if (clearDiv) begin
      next_s.pre = '0;
      next_s.divLo = '0;
      next_s.divHi = '0;
      next_s.mstate = 2'h0;
    end

    // reset pin pulse
    if (s.rstOutCnt != 5'h00) begin
      next_s.rstOutCnt = s.rstOutCnt - 5'h01;
    end

    // oscillator and status outputs from the next mode
    lowClk = (next_s.mode == DSC_SLOW) || (next_s.mode == DSC_SLEEP);
    next_s.out.hfOscOn = next_s.two[TWO_HF_EN] && !lowClk &&
      (next_s.mode != DSC_HALT1) && (next_s.mode != DSC_HALT2);
    next_s.out.lfOscOn = next_s.two[TWO_LF_EN] &&
      (next_s.mode != DSC_HALT1) && (next_s.mode != DSC_HALT2);
    next_s.out.lfPinsPort = !next_s.two[TWO_LF_EN];
    next_s.out.cpuRun = (next_s.mode == DSC_RUN1) ||
      (next_s.mode == DSC_RUN2) || (next_s.mode == DSC_SLOW);
    next_s.out.periphRun = next_s.out.cpuRun ||
      (next_s.mode == DSC_IDLE_SINGLE_CLOCK) || (next_s.mode == DSC_IDLE_DUAL_CLOCK) ||
      (next_s.mode == DSC_SLEEP);
    next_s.out.fmTick = fmTick;
    next_s.out.machineState = next_s.mstate;
    next_s.out.cycleEnd = fmTick && (s.mstate == 2'h3);

    if (softReset) begin
      next_s.one = ONE_RESET;
      next_s.two = TWO_RESET;
      next_s.gear = GEAR_RESET;
      next_s.timebase = TIMEBASE_RESET;
      next_s.mode = DSC_RUN1;
      next_s.pre = '0;
      next_s.divLo = '0;
      next_s.divHi = '0;
      next_s.mstate = 2'h0;
      next_s.rstOutCnt = RESET_OUT_CYCLES;
      next_s.out.hfOscOn = 1'b1;
      next_s.out.lfOscOn = 1'b0;
      next_s.out.lfPinsPort = 1'b1;
      next_s.out.cpuRun = 1'b1;
      next_s.out.periphRun = 1'b1;
      next_s.out.machineState = 2'h0;
    end
  end

  // ********************************************************
  // state register
  // ********************************************************
  always_ff @(posedge ref_clk or negedge rstN) begin
    if (!rstN) begin
      s <= '0;
      s.one <= ONE_RESET;
      s.two <= TWO_RESET;
      s.gear <= GEAR_RESET;
      s.timebase <= TIMEBASE_RESET;
      s.mode <= DSC_RUN1;
      s.out.hfOscOn <= 1'b1;
      s.out.lfPinsPort <= 1'b1;
      s.out.cpuRun <= 1'b1;
      s.out.periphRun <= 1'b1;
    end else begin
      s <= next_s;
    end
  end

  // ********************************************************
  // outputs
  // ********************************************************
  assign rdData = s.rdData;
  assign clkStatus = s.out;
  assign dividerValue = {s.divHi, s.divLo};
  assign modeNow = s.mode;
  assign resetPinOut = 1'b0;
  assign resetPinOe = (s.rstOutCnt != 5'h00);

endmodule

`default_nettype wire

// file: logic/dsc_pkg.sv
// package for the dual oscillator standby clock controller
// assumes one 125 MHz system clock and a plain register port
package dsc_pkg;

  // ********************************************************
  // register map
  // ********************************************************
  localparam int ADDR_W = 3;
  localparam logic [ADDR_W-1:0] ADDR_STANDBY_ONE = 3'h0;
  localparam logic [ADDR_W-1:0] ADDR_STANDBY_TWO = 3'h1;
  localparam logic [ADDR_W-1:0] ADDR_CLOCK_GEAR = 3'h2;
  localparam logic [ADDR_W-1:0] ADDR_TIMEBASE = 3'h3;

  // standby_control_one fields
  localparam int ONE_STOP = 7;
  localparam int ONE_RELEASE_TYPE = 6;
  localparam int ONE_POST_STOP = 5;
  localparam int ONE_WARMUP_HI = 3;
  localparam int ONE_WARMUP_LO = 2;
  // standby_control_two fields
  localparam int TWO_HF_EN = 7;
  localparam int TWO_LF_EN = 6;
  localparam int TWO_CLK_SEL = 5;
  localparam int TWO_IDLE = 4;
  localparam logic [7:0] TWO_READ_ONES = 8'h0f;
  // gear and timebase fields
  localparam int GEAR_DIV_INPUT = 5;
  localparam int TIMEBASE_SEVENTH = 4;

  // ********************************************************
  // reset values
  // ********************************************************
  localparam logic [7:0] ONE_RESET = 8'h00;
  localparam logic [7:0] TWO_RESET = 8'h80;
  localparam logic [7:0] GEAR_RESET = 8'h00;
  localparam logic [7:0] TIMEBASE_RESET = 8'h00;

  // ********************************************************
  // timing generator and counts
  // ********************************************************
  localparam int PRE_W = 3;
  localparam int DIV_W = 21;
  localparam int DIV_LO_W = 6;
  localparam int WARM_W = 19;
  // warm-up lengths in oscillator periods (before the gear doubling)
  localparam logic [WARM_W-1:0] WARM_HF_0 = 19'h30000;
  localparam logic [WARM_W-1:0] WARM_HF_1 = 19'h10000;
  localparam logic [WARM_W-1:0] WARM_HF_2 = 19'h0c000;
  localparam logic [WARM_W-1:0] WARM_HF_3 = 19'h04000;
  localparam logic [WARM_W-1:0] WARM_LF_0 = 19'h06000;
  localparam logic [WARM_W-1:0] WARM_LF_1 = 19'h02000;
  // reset pin pulled low for this long after both oscillators go off
  localparam real RESET_OUT_NS = 128.0;
  localparam real CLK_NS = 8.0;
  localparam logic [4:0] RESET_OUT_CYCLES =
    5'($rtoi(RESET_OUT_NS / CLK_NS));

  typedef enum logic [3:0] {
    DSC_RUN1, DSC_IDLE_SINGLE_CLOCK, DSC_HALT1, DSC_RUN2, DSC_SLOW,
    DSC_IDLE_DUAL_CLOCK, DSC_SLEEP, DSC_HALT2, DSC_WARM
  } dsc_mode_t;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [ADDR_W-1:0] addr;
    logic [7:0] wdata;
  } dsc_bus_t;

  typedef struct packed {
    logic fmTick;
    logic [1:0] machineState;
    logic cycleEnd;
    logic cpuRun;
    logic periphRun;
    logic hfOscOn;
    logic lfOscOn;
    logic lfPinsPort;
    logic idleWake;
    logic wakeToIsr;
  } dsc_clk_t;

endpackage

// file: verif/dsc_osc_model.sv
// oscillator sources for the standby clock controller
// assumes pins are sampled on ref_clk; a stopped source stands low
`timescale 1ns/10ps
`default_nettype none
module dsc_osc_model (
  input wire logic ref_clk, // system clock
  input wire logic hfOn, // hf oscillator enabled
  input wire logic lfOn, // lf oscillator enabled
  input wire logic hfSlow, // stretch hf half period
  output var logic hfPin, // hf source
  output var logic lfPin // lf source
);
  int hfCnt = 0;
  int lfCnt = 0;
  initial begin
    hfPin = 1'b0;
    lfPin = 1'b0;
  end
  // ********
  // sources
  // ********
  always @(posedge ref_clk) begin
    if (!hfOn) begin
      hfPin <= 1'b0;
      hfCnt <= 0;
    end else if (hfCnt >= (hfSlow ? 2 : 1)) begin
      hfPin <= ~hfPin;
      hfCnt <= 0;
    end else begin
      hfCnt <= hfCnt + 1;
    end
    if (!lfOn) begin
      lfPin <= 1'b0;
      lfCnt <= 0;
    end else if (lfCnt >= 7) begin
      lfPin <= ~lfPin;
      lfCnt <= 0;
    end else begin
      lfCnt <= lfCnt + 1;
    end
  end
endmodule
`default_nettype wire

// file: verif/dsc_standby_clock_assertions.sv
// port assertions for the standby clock controller
// bound into dsc_standby_clock; one clock domain
`timescale 1ns/10ps
`default_nettype none
module dsc_standby_clock_assertions (
  input wire logic ref_clk, // clock
  input wire logic reset_n, // reset, active low
  input wire dsc_pkg::dsc_bus_t bus, // register port
  input wire logic [7:0] rdData, // read data
  input wire logic hfClkPin, // hf source
  input wire logic intRequest, // interrupt request
  input wire logic intMasterEnable, // master enable
  input wire dsc_pkg::dsc_clk_t clkStatus, // status
  input wire logic [dsc_pkg::DIV_W-1:0] dividerValue, // divider
  input wire dsc_pkg::dsc_mode_t modeNow, // mode
  input wire logic resetPinOe // reset pin enable
);
  import dsc_pkg::*;
  // ********
  // properties
  // ********
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!reset_n);
  chk_end_tick: assert property (
    clkStatus.cycleEnd |-> clkStatus.fmTick)
    else $error("cycle end without tick");
  chk_state_step: assert property (
    $changed(clkStatus.machineState) && modeNow == DSC_RUN1 &&
    $past(modeNow) == DSC_RUN1 && !resetPinOe
    |-> clkStatus.machineState == $past(clkStatus.machineState) + 2'h1)
    else $error("machine state skipped");
  chk_fm_hf: assert property (
    modeNow == DSC_RUN1 && !resetPinOe && $past(reset_n, 3) &&
    $rose(hfClkPin)
    |-> ##[1:4] (clkStatus.fmTick || modeNow != DSC_RUN1))
    else $error("no main tick after hf edge");
  chk_idle_wake: assert property (
    modeNow == DSC_IDLE_SINGLE_CLOCK && intRequest |=> modeNow == DSC_RUN1 &&
    clkStatus.idleWake && clkStatus.wakeToIsr == $past(intMasterEnable))
    else $error("idle wake wrong");
  chk_dual_wake: assert property (
    modeNow == DSC_IDLE_DUAL_CLOCK && intRequest |=> modeNow == DSC_RUN2)
    else $error("dual idle wake wrong");
  chk_sleep_wake: assert property (
    modeNow == DSC_SLEEP && intRequest |=> modeNow == DSC_SLOW)
    else $error("sleep wake wrong");
  chk_slow_osc: assert property (
    modeNow inside {DSC_SLOW, DSC_SLEEP} |->
    !clkStatus.hfOscOn && clkStatus.lfOscOn)
    else $error("slow oscillators wrong");
  chk_low_hold: assert property (
    modeNow == DSC_SLOW && $past(modeNow) == DSC_SLOW |->
    $stable(dividerValue[5:0]))
    else $error("low divider stages moved");
  chk_dual_pins: assert property (
    modeNow == DSC_RUN2 |-> clkStatus.hfOscOn && clkStatus.lfOscOn &&
    !clkStatus.lfPinsPort)
    else $error("dual mode status wrong");
  chk_halt_clear: assert property (
    modeNow == DSC_HALT1 |-> dividerValue == '0 && !clkStatus.hfOscOn)
    else $error("stop did not clear");
  chk_warm_halt: assert property (
    modeNow == DSC_WARM |-> !clkStatus.cpuRun && !clkStatus.periphRun)
    else $error("warm-up not halted");
  chk_reset_out: assert property (
    $rose(resetPinOe) |-> resetPinOe[*8] ##1 resetPinOe[*8] ##1 !resetPinOe)
    else $error("reset pin pulse length wrong");
  chk_read_quiet: assert property (
    rdData != 8'h00 |-> $past(bus.rd))
    else $error("read data outside read");
  cover property (modeNow == DSC_IDLE_SINGLE_CLOCK && intRequest);
  cover property (modeNow == DSC_SLEEP && intRequest);
  cover property ($rose(resetPinOe));
  cover property (modeNow == DSC_HALT2);
  cover property (modeNow == DSC_WARM ##1 modeNow == DSC_RUN1);
endmodule
bind dsc_standby_clock dsc_standby_clock_assertions dsc_chk_inst (
  .ref_clk(ref_clk), .reset_n(reset_n), .bus(bus), .rdData(rdData),
  .hfClkPin(hfClkPin), .intRequest(intRequest),
  .intMasterEnable(intMasterEnable), .clkStatus(clkStatus),
  .dividerValue(dividerValue), .modeNow(modeNow),
  .resetPinOe(resetPinOe));
`default_nettype wire

// file: verif/tb.sv
// self-checking bench for the standby clock controller
// assumes dsc_osc_model on the oscillator pins
`timescale 1ns/10ps
`default_nettype none
module tb;
  import dsc_pkg::*;
  logic ref_clk;
  logic reset_n;
  dsc_bus_t bus;
  logic [7:0] rdData;
  logic hfClkPin;
  logic lfClkPin;
  logic stopReleasePin;
  logic intRequest;
  logic intMasterEnable;
  logic hfSlow;
  dsc_clk_t clkStatus;
  logic [DIV_W-1:0] dividerValue;
  logic [DIV_W-1:0] held;
  dsc_mode_t modeNow;
  logic resetPinOut;
  logic resetPinOe;
  logic [7:0] rv;
  int miscompares = 0;
  int checked = 0;
  int seed = 32'hb934d2dd;
  int n;
  dsc_standby_clock dsc_standby_clock_inst (.ref_clk(ref_clk),
    .reset_n(reset_n), .bus(bus), .rdData(rdData), .hfClkPin(hfClkPin),
    .lfClkPin(lfClkPin), .stopReleasePin(stopReleasePin),
    .intRequest(intRequest), .intMasterEnable(intMasterEnable),
    .clkStatus(clkStatus), .dividerValue(dividerValue), .modeNow(modeNow),
    .resetPinIn(1'b1), .resetPinOut(resetPinOut), .resetPinOe(resetPinOe));
  dsc_osc_model dsc_osc_model_inst (.ref_clk(ref_clk),
    .hfOn(clkStatus.hfOscOn), .lfOn(clkStatus.lfOscOn), .hfSlow(hfSlow),
    .hfPin(hfClkPin), .lfPin(lfClkPin));
  // ********
  // helpers
  // ********
  initial begin
    ref_clk = 1'b0;
    forever #4 ref_clk = ~ref_clk;
  end
  task automatic end_sim();
    $display("comparisons %0d mismatches %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  task automatic cmp(input string what, input logic [31:0] exp,
      input logic [31:0] got);
    checked++;
    if (got !== exp) begin
      miscompares++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask
  function automatic logic [7:0] exp_reset(input logic [2:0] a);
    return (a == ADDR_STANDBY_TWO) ? 8'h8f : 8'h00;
  endfunction
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    bus <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(posedge ref_clk);
    bus <= '0;
  endtask
  task automatic rd(input logic [2:0] a, output logic [7:0] d);
    @(posedge ref_clk);
    bus <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
    @(posedge ref_clk);
    bus <= '0;
    #1 d = rdData;
  endtask
  task automatic wait_mode(input dsc_mode_t m, input int limit);
    #1 n = 0;
    while (modeNow !== m && n < limit) begin
      @(posedge ref_clk);
      #1 n++;
    end
    if (modeNow !== m) begin
      cmp("mode wait", m, modeNow);
      end_sim();
    end
  endtask
  task automatic wake();
    @(posedge ref_clk);
    intRequest <= 1'b1;
    @(posedge ref_clk);
    intRequest <= 1'b0;
    #1 cmp("wake pulse", 1, clkStatus.idleWake);
  endtask
  task automatic pulse_reset();
    reset_n <= 1'b0;
    repeat (2) @(posedge ref_clk);
    reset_n <= 1'b1;
    repeat (3) @(posedge ref_clk);
  endtask
  // ********
  // scenarios
  // ********
  initial begin
    reset_n = 1'b0;
    bus = '0;
    stopReleasePin = 1'b0;
    intRequest = 1'b0;
    intMasterEnable = 1'b0;
    hfSlow = 1'b0;
    repeat (20) @(posedge ref_clk);
    reset_n <= 1'b1;
    repeat (3) @(posedge ref_clk);
    cmp("reset mode", DSC_RUN1, modeNow);
    for (int a = 0; a < 8; a++) begin
      rd(3'(a), rv);
      cmp("reset read", exp_reset(3'(a)), rv);
    end
    wr(ADDR_CLOCK_GEAR, 8'h20);
    wr(ADDR_TIMEBASE, 8'h00);
    #1 held = dividerValue;
    repeat (256) @(posedge ref_clk);
    #1 rv = {2'b00, 6'(dividerValue[5:0] - held[5:0])};
    cmp("fc/8 input", 1, rv >= 8'h07 && rv <= 8'h09);
    for (int i = 0; i < 4; i++) begin
      @(posedge ref_clk);
      rv = 8'($random(seed));
      hfSlow <= rv[0];
      intMasterEnable <= rv[1];
      wr(ADDR_STANDBY_TWO, 8'h90);
      #1 cmp("idle", DSC_IDLE_SINGLE_CLOCK, modeNow);
      cmp("cpu halted", 0, clkStatus.cpuRun);
      cmp("periph on", 1, clkStatus.periphRun);
      wr(ADDR_STANDBY_TWO, 8'h00);
      #1 cmp("idle refuses", 0, resetPinOe);
      wake();
      cmp("idle wake", DSC_RUN1, modeNow);
      cmp("to service", rv[1], clkStatus.wakeToIsr);
    end
    rv = 8'($random(seed));
    wr(ADDR_STANDBY_TWO, {4'hc, rv[3:0]});
    wait_mode(DSC_RUN2, 4);
    cmp("lf pins", 0, clkStatus.lfPinsPort);
    rd(ADDR_STANDBY_TWO, rv);
    cmp("dual read", 8'hcf, rv);
    wr(ADDR_STANDBY_TWO, 8'hd0);
    wait_mode(DSC_IDLE_DUAL_CLOCK, 4);
    wake();
    cmp("idle_dual_clock wake", DSC_RUN2, modeNow);
    wr(ADDR_STANDBY_TWO, 8'he0);
    wait_mode(DSC_SLOW, 100);
    cmp("hf off", 0, clkStatus.hfOscOn);
    rd(ADDR_STANDBY_TWO, rv);
    cmp("select read", 8'hef, rv);
    held = dividerValue;
    repeat (64) @(posedge ref_clk);
    cmp("low stages", held[5:0], dividerValue[5:0]);
    cmp("seventh runs", 1, held[20:6] !== dividerValue[20:6]);
    wr(ADDR_STANDBY_TWO, 8'hf0);
    wait_mode(DSC_SLEEP, 4);
    wake();
    cmp("sleep wake", DSC_SLOW, modeNow);
    wr(ADDR_STANDBY_ONE, 8'hb0);
    wait_mode(DSC_HALT2, 4);
    cmp("halt2 osc", 0, {clkStatus.hfOscOn, clkStatus.lfOscOn});
    pulse_reset();
    cmp("halt2 reset", DSC_RUN1, modeNow);
    wr(ADDR_STANDBY_TWO, 8'hc0);
    wait_mode(DSC_RUN2, 100);
    wr(ADDR_STANDBY_TWO, 8'h00);
    repeat (2) @(posedge ref_clk);
    #1 cmp("reset out", 1, resetPinOe);
    cmp("reset pin level", 0, resetPinOut);
    wait_mode(DSC_RUN1, 40);
    repeat (20) @(posedge ref_clk);
    rd(ADDR_STANDBY_TWO, rv);
    cmp("after reset out", 8'h8f, rv);
    wr(ADDR_STANDBY_ONE, 8'h90);
    wait_mode(DSC_HALT1, 4);
    cmp("stop clears", 0, dividerValue);
    repeat (20) @(posedge ref_clk);
    #1 cmp("stays stopped", DSC_HALT1, modeNow);
    pulse_reset();
    cmp("reset release", DSC_RUN1, modeNow);
    stopReleasePin <= 1'b1;
    wr(ADDR_STANDBY_ONE, 8'hdc);
    wait_mode(DSC_WARM, 8);
    pulse_reset();
    stopReleasePin <= 1'b0;
    hfSlow <= 1'b0;
    wr(ADDR_STANDBY_ONE, 8'h9c);
    wait_mode(DSC_HALT1, 4);
    repeat (8) @(posedge ref_clk);
    stopReleasePin <= 1'b1;
    wait_mode(DSC_WARM, 8);
    @(posedge ref_clk);
    stopReleasePin <= 1'b0;
    wait_mode(DSC_RUN1, 80000);
    cmp("warm length", 1, n >= int'(WARM_HF_3) * 4 - 64);
    cmp("warm upper", 1, n <= int'(WARM_HF_3) * 4 + 64);
    cmp("release clears", 0, dividerValue);
    end_sim();
  end
endmodule
`default_nettype wire
